// ===== tw_cfg.svh
`ifndef TW_CFG_SVH
`define TW_CFG_SVH

// Device type codes in the top nibble of the slave address byte
`define TW_TYPE_MEM 4'hA
`define TW_TYPE_ID 4'hB

// Bit of the high address byte that selects the lock command (A10)
`define TW_LOCK_SEL_BIT 2
// Bit of the lock data byte that must be set
`define TW_LOCK_DATA_BIT 1
// Read/write bit position in the slave address byte
`define TW_RW_BIT 0

// Bit counter values: last data bit seen, acknowledge slot
`define TW_BIT_BYTE 4'h8
`define TW_BIT_ACK 4'h9

// Page geometry
`define TW_PAGE_BYTES 128
`define TW_PAGE_BITS 7

// Self-timed programming time and system clock period, both in ns
`define TW_T_WR_NS 5000000
`define TW_CLK_NS 100
// Longest time: round down to whole cycles, at least one
`define TW_WR_CYCLES ((`TW_T_WR_NS / `TW_CLK_NS) < 1 ? 1 : \
   (`TW_T_WR_NS / `TW_CLK_NS))

// Idle level of the bus lines
`define TW_LINE_IDLE 1'h1

`endif

// ===== tw_pkg.sv
package tw_pkg;

   // Bus side protocol phase
   typedef enum logic [2:0] {
      TW_IDLE,
      TW_DEV,
      TW_AHI,
      TW_ALO,
      TW_DATA
   } tw_phase_e;

   // Self-timed programming engine state
   typedef enum logic [1:0] {
      TWP_IDLE,
      TWP_SWEEP,
      TWP_WAIT
   } tw_prog_e;

endpackage : tw_pkg

// ===== tw_sync.sv
`timescale 1ns/100ps
`include "tw_cfg.svh"

module tw_sync #(
   parameter int W = 1
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);

   // First stage, read only by the second stage
   logic [W-1:0] meta;

   // Two flops; reset to the idle bus level so no false edge follows reset
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         meta <= {W{`TW_LINE_IDLE}};
         sync_o <= {W{`TW_LINE_IDLE}};
      end else begin
         meta <= async_i;
         sync_o <= meta;
      end
   end

endmodule : tw_sync

// ===== tw_eeprom_slave.sv
// Contract
// - Start: data falls while clock high
// - Stop: data rises while clock high
// - Data changes only with clock low
// - Ignore bus until a start is seen
// - Receiver acknowledges each received byte
// - Any start resets the bus logic
// - Standby after power-up, stop, write done
// - Accept only the memory or identification device type
// - Next three bits match chip selects
// - Last address bit: one read, zero write
// - Acknowledge matching address in ninth clock
// - Byte write programs at the stop
// - Ignore bus while programming
// - Page write up to 128 bytes
// - Increment only seven low address bits
// - Extra bytes overwrite buffered page bytes
// - Withhold address acknowledge while busy
// - Identification page write, type 1011b, A10 clear
// - Locked identification page: no data acknowledge
// - Lock command: A10 set, data bit1
// - Lock is permanent and irreversible
// - Write-protect pin high blocks writes
// - Floating chip selects read as zero
`timescale 1ns/100ps
`include "tw_cfg.svh"

module tw_eeprom_slave
   import tw_pkg::*;
#(
   parameter int WR_CYCLES = `TW_WR_CYCLES
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic chip_select_bit_zero_i,
   input wire logic chip_select_bit_one_i,
   input wire logic chip_select_bit_two_i,
   input wire logic write_protect_i,
   input wire logic lock_init_i,
   output logic sda_o,
   output logic sda_oe_o,
   output logic busy_o,
   output logic id_locked_o,
   output logic mem_we_o,
   output logic mem_id_sel_o,
   output logic [15:0] mem_addr_o,
   output logic [7:0] mem_data_o
);

   // Synchronised pins: clock, data, chip selects, write protect
   logic [5:0] pins_s;
   logic scl_s;
   logic sda_s;
   logic [2:0] cs_s;
   logic wp_s;
   // Previous sampled line levels for edge finding
   logic scl_q;
   logic sda_q;

   // Bus side state
   tw_phase_e phase;
   logic [3:0] bitcnt;
   logic [7:0] shreg;
   logic cont;
   logic is_id;
   logic [7:0] addr_hi;
   logic [8:0] page_base;
   logic [6:0] ptr;
   logic wr_any;
   logic lock_req;
   // Page buffer and per-byte valid marks
   logic [7:0] pbuf [`TW_PAGE_BYTES];
   logic [`TW_PAGE_BYTES-1:0] vld;

   // Programming engine state
   tw_prog_e prog;
   logic [7:0] idx;
   logic [31:0] tmr;
   logic prog_id;
   logic prog_lock;
   logic [8:0] prog_base;

   // Bus, chip select and protect pins cross into the clock domain through two flops
   tw_sync #(.W(6)) u_sync (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .async_i({scl_i, sda_i, chip_select_bit_two_i,
                chip_select_bit_one_i, chip_select_bit_zero_i,
                write_protect_i}),
      .sync_o(pins_s)
   );

   assign scl_s = pins_s[5];
   assign sda_s = pins_s[4];
   // Pins left open are pulled to zero on the board side
   assign cs_s = pins_s[3:1];
   assign wp_s = pins_s[0];

   // Line edges and bus conditions
   wire scl_rise = scl_s & ~scl_q;
   wire scl_fall = ~scl_s & scl_q;
   wire scl_high = scl_s & scl_q;
   wire start_det = scl_high & sda_q & ~sda_s;
   wire stop_det = scl_high & ~sda_q & sda_s;
   wire busy = (prog != TWP_IDLE);

   // Byte boundary and acknowledge slot end, both on clock fall
   wire byte_end = scl_fall & (bitcnt == `TW_BIT_BYTE);
   wire ack_end = scl_fall & (bitcnt == `TW_BIT_ACK);

   // Slave address decode
   wire [3:0] dev_type = shreg[7:4];
   wire type_mem = (dev_type == `TW_TYPE_MEM);
   wire type_id = (dev_type == `TW_TYPE_ID);
   wire cs_ok = (shreg[3:1] == cs_s);
   wire is_read = shreg[`TW_RW_BIT];
   // Address answered only when idle, which gives polling its meaning
   wire dev_ok = (type_mem | type_id) & cs_ok & ~busy;

   // Lock command selected by A10 of the identification access
   wire lock_cmd = is_id & addr_hi[`TW_LOCK_SEL_BIT];
   // Locked page refuses its data bytes
   wire id_refused = is_id & ~lock_cmd & id_locked_o;
   wire store_ok = ~lock_cmd & ~id_refused;

   // Acknowledge decision for the byte just received
   wire give_ack = (phase == TW_DEV) ? dev_ok :
                   (phase == TW_DATA) ? ~id_refused :
                   1'h1;

   // Next phase after a byte that was acknowledged
   wire [2:0] nxt_raw = (phase == TW_DEV) ? 3'(TW_AHI) :
                        (phase == TW_AHI) ? 3'(TW_ALO) :
                        3'(TW_DATA);

   // Programming launch on stop; protect pin skips the cycle
   wire launch = stop_det & (wr_any | lock_req) & ~wp_s & ~busy;

   // Previous line levels, reset to idle bus
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         scl_q <= `TW_LINE_IDLE;
         sda_q <= `TW_LINE_IDLE;
      end else begin
         scl_q <= scl_s;
         sda_q <= sda_s;
      end
   end

   // Protocol phase: start restarts it, stop ends it
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         phase <= TW_IDLE;
      end else if (start_det) begin
         phase <= TW_DEV;
      end else if (stop_det) begin
         phase <= TW_IDLE;
      end else if (ack_end) begin
         // Refused or read address drops back to waiting for a start
         phase <= cont ? tw_phase_e'(nxt_raw) : TW_IDLE;
      end
   end

   // Bit counter: counts rising clocks, wraps after the ack slot
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         bitcnt <= 4'h0;
      end else if (start_det | stop_det) begin
         bitcnt <= 4'h0;
      end else if (phase == TW_IDLE) begin
         bitcnt <= 4'h0;
      end else if (ack_end) begin
         bitcnt <= 4'h0;
      end else if (byte_end) begin
         bitcnt <= `TW_BIT_ACK;
      end else if (scl_rise && bitcnt < `TW_BIT_BYTE) begin
         bitcnt <= bitcnt + 4'h1;
      end
   end

   // Shift in one bit per rising clock, most significant first
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         shreg <= 8'h00;
      end else if (scl_rise && phase != TW_IDLE && bitcnt < `TW_BIT_BYTE) begin
         shreg <= {shreg[6:0], sda_s};
      end
   end

   // Acknowledge drive: held low from byte end to the ack slot end
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         sda_oe_o <= 1'h0;
         sda_o <= 1'h0;
         cont <= 1'h0;
      end else if (start_det | stop_det | ack_end) begin
         sda_oe_o <= 1'h0;
      end else if (byte_end && phase != TW_IDLE) begin
         sda_oe_o <= give_ack;
         // Reads are answered at address time but not served here
         cont <= give_ack & ~((phase == TW_DEV) & is_read);
      end
   end

   // Address capture: high byte, then low byte
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         is_id <= 1'h0;
         addr_hi <= 8'h00;
         page_base <= 9'h000;
      end else if (byte_end && phase == TW_DEV) begin
         is_id <= type_id;
      end else if (byte_end && phase == TW_AHI) begin
         addr_hi <= shreg;
      end else if (byte_end && phase == TW_ALO) begin
         page_base <= {addr_hi, shreg[7]};
      end
   end

   // In-page pointer: only the seven low bits move
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         ptr <= 7'h00;
      end else if (byte_end && phase == TW_ALO) begin
         ptr <= shreg[6:0];
      end else if (byte_end && phase == TW_DATA && store_ok) begin
         ptr <= ptr + 7'h01;
      end
   end

   // Pending work; cleared at stop after launch sampled it
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         wr_any <= 1'h0;
         lock_req <= 1'h0;
      end else if (stop_det | (start_det & ~busy)) begin
         wr_any <= 1'h0;
         lock_req <= 1'h0;
      end else if (byte_end && phase == TW_DATA && lock_cmd) begin
         lock_req <= shreg[`TW_LOCK_DATA_BIT];
      end else if (byte_end && phase == TW_DATA && store_ok) begin
         wr_any <= 1'h1;
      end
   end

   // Valid marks; kept while busy since the sweep still reads them
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         vld <= '0;
      end else if (start_det & ~busy) begin
         vld <= '0;
      end else if (byte_end && phase == TW_DATA && store_ok) begin
         vld[ptr] <= 1'h1;
      end
   end

   // Page buffer; a repeat position simply overwrites
   always_ff @(posedge sys_clk_i) begin
      if (byte_end && phase == TW_DATA && store_ok) begin
         pbuf[ptr] <= shreg;
      end
   end

   // Programming engine: sweep buffer, then wait the write time
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         prog <= TWP_IDLE;
         idx <= 8'h00;
         tmr <= 32'h0;
         prog_id <= 1'h0;
         prog_lock <= 1'h0;
         prog_base <= 9'h000;
      end else begin
         case (prog)
            TWP_IDLE: begin
               if (launch) begin
                  prog <= TWP_SWEEP;
                  idx <= 8'h00;
                  prog_id <= is_id;
                  prog_lock <= lock_req;
                  prog_base <= page_base;
               end
            end
            TWP_SWEEP: begin
               // One buffer byte per cycle, whole page in 128 cycles
               if (idx[`TW_PAGE_BITS]) begin
                  prog <= TWP_WAIT;
                  tmr <= 32'h0;
               end else begin
                  idx <= idx + 8'h01;
               end
            end
            TWP_WAIT: begin
               // Inputs stay ignored until the time runs out
               if (tmr >= 32'(WR_CYCLES - 1)) begin
                  prog <= TWP_IDLE;
               end else begin
                  tmr <= tmr + 32'h1;
               end
            end
            default: begin
               prog <= TWP_IDLE;
            end
         endcase
      end
   end

   // Array write port, one registered byte per sweep cycle
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         mem_we_o <= 1'h0;
         mem_id_sel_o <= 1'h0;
         mem_addr_o <= 16'h0000;
         mem_data_o <= 8'h00;
      end else if (prog == TWP_SWEEP && !idx[`TW_PAGE_BITS]) begin
         // Lock command writes nothing to the array
         mem_we_o <= vld[idx[6:0]] & ~prog_lock;
         mem_id_sel_o <= prog_id;
         // Identification page ignores the upper address bits
         mem_addr_o <= {prog_id ? 9'h000 : prog_base, idx[6:0]};
         mem_data_o <= pbuf[idx[6:0]];
      end else begin
         mem_we_o <= 1'h0;
      end
   end

   // Lock flag: loaded from storage at reset, set once, never cleared
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         id_locked_o <= lock_init_i;
      end else if (prog == TWP_SWEEP && prog_lock) begin
         id_locked_o <= 1'h1;
      end
   end

   // Busy indication for the outside world
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         busy_o <= 1'h0;
      end else begin
         busy_o <= busy | launch;
      end
   end

endmodule : tw_eeprom_slave

// ===== tw_eeprom_slave_monitor.sv
`timescale 1ns/100ps
module tw_eeprom_slave_monitor #(
   parameter int WR_CYCLES = 20
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic write_protect_i,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic busy_o,
   input wire logic id_locked_o,
   input wire logic mem_we_o,
   input wire logic mem_id_sel_o
);
   // Length of the current busy stretch
   logic [15:0] busy_cnt;

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   // Counts busy cycles, cleared whenever idle
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i || !busy_o) begin
         busy_cnt <= 16'h0;
      end else begin
         busy_cnt <= busy_cnt + 16'h1;
      end
   end

   a_ack_not_busy: assert property (
      busy_o && $past(busy_o) |-> !sda_oe_o) else $error("ack while busy");
   a_write_in_busy: assert property (
      mem_we_o |-> busy_o) else $error("array write outside busy");
   a_lock_sticky: assert property (
      $past(id_locked_o) && $past(rst_n_i) |-> id_locked_o)
      else $error("lock state dropped");
   a_wp_blocks: assert property (
      $rose(busy_o) |-> !$past(write_protect_i, 3))
      else $error("programming while protected");
   a_ack_width: assert property (
      $rose(sda_oe_o) |-> sda_oe_o[*6]) else $error("ack pulse too short");
   a_busy_ends: assert property (
      $rose(busy_o) |-> ##[1:400] !busy_o) else $error("busy never ends");
   a_locked_no_id: assert property (
      mem_we_o && mem_id_sel_o |-> !id_locked_o)
      else $error("locked page written");
   a_open_drain: assert property (
      sda_oe_o |-> !sda_o) else $error("data pin driven high");
   a_busy_min: assert property (
      $fell(busy_o) |-> busy_cnt >= WR_CYCLES) else $error("busy too short");

   // Main scenarios reached
   c_prog: cover property ($rose(busy_o));
   c_ack: cover property ($rose(sda_oe_o));
   c_id_write: cover property (mem_we_o && mem_id_sel_o);
   c_lock: cover property ($rose(id_locked_o));
endmodule : tw_eeprom_slave_monitor

// ===== tw_master_model.sv
`timescale 1ns/100ps
module tw_master_model (
   input wire logic sys_clk_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_low_o
);
   // Idle bus: clock parked high, data released to the pull-up
   initial begin
      scl_o = 1'h1;
      sda_low_o = 1'h0;
   end

   // Quarter bus period is two system clocks
   task automatic tick(input int n);
      repeat (n) @(negedge sys_clk_i);
   endtask : tick

   // Start or repeated start: data falls with clock high
   task automatic start;
      sda_low_o = 1'h0;
      tick(2);
      scl_o = 1'h1;
      tick(2);
      sda_low_o = 1'h1;
      tick(2);
      scl_o = 1'h0;
      tick(2);
   endtask : start

   // Stop: data rises with clock high
   task automatic stop;
      sda_low_o = 1'h1;
      tick(2);
      scl_o = 1'h1;
      tick(2);
      sda_low_o = 1'h0;
      tick(4);
   endtask : stop

   // One clock pulse; data only moves while the clock is low
   task automatic bit_io(input logic b, output logic got);
      sda_low_o = !b;
      tick(2);
      scl_o = 1'h1;
      tick(2);
      got = sda_i;
      tick(2);
      scl_o = 1'h0;
      tick(2);
   endtask : bit_io

   // Byte MSB first, then the ninth pulse with data released
   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic got;
      for (int i = 7; i >= 0; i--) begin
         bit_io(b[i], got);
      end
      bit_io(1'h1, got);
      ack = !got;
   endtask : wbyte

   // Bus recovery: clock until data reads high, then a fresh start
   task automatic recover;
      logic got;
      for (int i = 0; i < 9; i++) begin
         bit_io(1'h1, got);
         if (got) break;
      end
      start();
   endtask : recover
endmodule : tw_master_model

// ===== test_tw_eeprom_slave.sv
`timescale 1ns/100ps
module test_tw_eeprom_slave;
   logic sys_clk_i, rst_n_i, write_protect_i, lock_init_i;
   logic [2:0] cs; // Chip select straps
   logic scl, m_low, sda_w; // Bus wires and master pull-down
   logic sda_o, sda_oe_o, busy_o, id_locked_o, mem_we_o, mem_id_sel_o;
   logic [15:0] mem_addr_o;
   logic [7:0] mem_data_o;
   logic [24:0] wq[$]; // Captured writes: id select, address, data
   logic [7:0] adr[4];
   logic ack_e[4];
   int err_count, checks_done;

   // Open-drain wire with pull-up
   assign sda_w = (m_low || (sda_oe_o && !sda_o)) ? 1'h0 : 1'h1;

   always #50 sys_clk_i = ~sys_clk_i;

   tw_eeprom_slave #(.WR_CYCLES(20)) u_dut (.sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda_w),
      .chip_select_bit_zero_i(cs[0]), .chip_select_bit_one_i(cs[1]),
      .chip_select_bit_two_i(cs[2]), .write_protect_i(write_protect_i),
      .lock_init_i(lock_init_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
      .busy_o(busy_o), .id_locked_o(id_locked_o), .mem_we_o(mem_we_o),
      .mem_id_sel_o(mem_id_sel_o), .mem_addr_o(mem_addr_o),
      .mem_data_o(mem_data_o));

   tw_master_model u_mst (.sys_clk_i(sys_clk_i), .sda_i(sda_w),
      .scl_o(scl), .sda_low_o(m_low));

   // Records every byte handed to the array
   always @(posedge sys_clk_i) begin
      if (mem_we_o === 1'h1) begin
         wq.push_back({mem_id_sel_o, mem_addr_o, mem_data_o});
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %0h exp %0h", $time, got, exp);
      end
   endtask : chk

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : tally_and_finish

   // Sends a byte and compares the acknowledge
   task automatic send(input logic [7:0] b, input logic exp);
      logic a;
      u_mst.wbyte(b, a);
      chk(a, exp);
   endtask : send

   // Write transfer: device, two address bytes, n counting data bytes
   task automatic wr(input logic [7:0] dev, input logic [15:0] a,
         input int n, input logic [7:0] d0, input logic dack);
      u_mst.start();
      send(dev, 1'h1);
      send(a[15:8], 1'h1);
      send(a[7:0], 1'h1);
      for (int i = 0; i < n; i++) begin
         send(d0 + 8'(i), dack);
      end
      u_mst.stop();
   endtask : wr

   // Checks whether programming starts, then waits it out, bounded
   task automatic settle(input logic exp);
      int k;
      k = 0;
      while (busy_o !== 1'h1 && k < 20) begin
         @(negedge sys_clk_i);
         k++;
      end
      chk(busy_o, exp);
      k = 0;
      while (busy_o !== 1'h0 && k < 600) begin
         @(negedge sys_clk_i);
         k++;
      end
      if (k == 600) begin
         err_count++;
         tally_and_finish();
      end
   endtask : settle

   initial begin
      sys_clk_i = 1'h0;
      rst_n_i = 1'h0;
      write_protect_i = 1'h0;
      lock_init_i = 1'h0;
      cs = 3'h5;
      err_count = 0;
      checks_done = 0;
      adr = '{8'hAA, 8'hAB, 8'hA2, 8'h9A};
      ack_e = '{1'h1, 1'h1, 1'h0, 1'h0};
      // Two cycles; synchronisers reset to the idle line level
      repeat (2) @(negedge sys_clk_i);
      rst_n_i = 1'h1;
      repeat (4) @(negedge sys_clk_i);
      chk(id_locked_o, 1'h0);
      chk(busy_o, 1'h0);
      // A byte with no start ahead of it is ignored
      send(8'hAA, 1'h0);
      for (int i = 0; i < 4; i++) begin
         u_mst.start();
         send(adr[i], ack_e[i]);
         u_mst.stop();
      end
      $display("addressing test done");
      wq.delete();
      wr(8'hAA, 16'h1234, 1, 8'h5A, 1'h1);
      u_mst.start();
      send(8'hAA, 1'h0);
      u_mst.stop();
      settle(1'h1);
      u_mst.start();
      send(8'hAA, 1'h1);
      u_mst.stop();
      chk(wq.size(), 1);
      chk(wq[0], {1'h0, 16'h1234, 8'h5A});
      $display("byte write test done");
      // 130 bytes from offset 7E: wraps, last two overwrite 7E and 7F
      wq.delete();
      wr(8'hAA, 16'h057E, 130, 8'h00, 1'h1);
      settle(1'h1);
      chk(wq.size(), 128);
      for (int o = 0; o < 128; o++) begin
         chk(wq[o], {1'h0, 16'h0500 + 16'(o),
            (o >= 126) ? 8'(o + 2) : 8'(o + 2)});
      end
      $display("page write test done");
      write_protect_i = 1'h1;
      wq.delete();
      wr(8'hAA, 16'h0010, 2, 8'h11, 1'h1);
      settle(1'h0);
      chk(wq.size(), 0);
      write_protect_i = 1'h0;
      $display("protect test done");
      wq.delete();
      wr(8'hBA, 16'hFB05, 1, 8'h33, 1'h1);
      settle(1'h1);
      chk(wq[0], {1'h1, 16'h0005, 8'h33});
      wr(8'hBA, 16'h0400, 1, 8'h02, 1'h1);
      settle(1'h1);
      chk(id_locked_o, 1'h1);
      wq.delete();
      wr(8'hBA, 16'h0005, 1, 8'h44, 1'h0);
      settle(1'h0);
      chk(wq.size(), 0);
      $display("id page test done");
      // Restart mid-data discards the half-done write
      wq.delete();
      wr(8'hAA, 16'h0020, 0, 8'h00, 1'h1);
      u_mst.start();
      send(8'hAA, 1'h1);
      send(8'h00, 1'h1);
      send(8'h20, 1'h1);
      send(8'h77, 1'h1);
      // Cut the next byte short, recover, then end the transfer
      u_mst.recover();
      u_mst.stop();
      settle(1'h0);
      chk(wq.size(), 0);
      $display("abort test done");
      // Power cycle with the stored lock set: the page stays locked
      lock_init_i = 1'h1;
      rst_n_i = 1'h0;
      repeat (2) @(negedge sys_clk_i);
      rst_n_i = 1'h1;
      chk(id_locked_o, 1'h1);
      wq.delete();
      wr(8'hBA, 16'h0001, 1, 8'h55, 1'h0);
      settle(1'h0);
      chk(wq.size(), 0);
      $display("power cycle test done");
      tally_and_finish();
   end
endmodule : test_tw_eeprom_slave

bind tw_eeprom_slave tw_eeprom_slave_monitor #(.WR_CYCLES(WR_CYCLES)) u_mon (
   .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
   .write_protect_i(write_protect_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
   .busy_o(busy_o), .id_locked_o(id_locked_o), .mem_we_o(mem_we_o),
   .mem_id_sel_o(mem_id_sel_o));
